// ---- pll_synth.sv ----
// Synthesizer core top: registers, input selection, phase comparator, charge pump
`timescale 1ns/1ps
`include "pll_synth_consts.svh"
module pll_synth (
    // Clock and resets
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    input  wire logic        wdt_reset_i,
    input  wire logic        clock_stop_i,

    // Peripheral register port
    input  wire logic [6:0]  reg_addr_i,
    input  wire logic        reg_wr_i,
    input  wire logic [3:0]  reg_wdata_i,
    input  wire logic        periph_read_instr_i,
    output      logic [3:0]  reg_rdata_o,

    // Divider data register write
    input  wire logic        periph_write_instr_i,
    input  wire logic [15:0] divider_data_reg_i,

    // Oscillator and crystal inputs
    input  wire logic        low_band_osc_in_i,
    input  wire logic        high_band_osc_in_i,
    input  wire logic        xtal_75k_i,

    // Input pull-down controls
    output      logic        low_band_pd_o,
    output      logic        high_band_pd_o,

    // Error outputs, three-state
    output      logic        error_out_a_o,
    output      logic        error_out_a_oe_o,
    output      logic        error_out_b_o,
    output      logic        error_out_b_oe_o,

    // Comparator requests
    output      logic        up_request_n_o,
    output      logic        down_request_n_o
);

    // ============================================================
    // Registers
    logic [1:0]  div_mode;
    logic        swallow_lsb_flag;
    logic [2:0]  ref_sel;
    logic [16:0] divisor;
    logic        lock_loss_bit;

    wire logic div_mode_hi = div_mode[1];
    wire logic div_mode_lo = div_mode[0];
    wire logic wr_mode     = reg_wr_i && (reg_addr_i == `ADDR_MODE_SEL);
    wire logic wr_ref      = reg_wr_i && (reg_addr_i == `ADDR_REF_SEL);
    wire logic rd_lock     = periph_read_instr_i && (reg_addr_i == `ADDR_LOCK_LOSS);
    wire logic any_reset   = rst_i || wdt_reset_i || clock_stop_i;

    // Codes 110 and 111 disable the whole synthesizer
    wire logic synth_off   = ref_sel[2] && ref_sel[1];

    // No halt input reaches these registers, so a halted CPU leaves them running
    always_ff @(posedge sys_clk_i) begin
        if (any_reset) begin
            ref_sel <= `REF_SEL_RESET;
        end else if (wr_ref) begin
            ref_sel <= reg_wdata_i[2:0];
        end
    end

    // Clock stop keeps the swallow flag, pin and watchdog resets clear it
    always_ff @(posedge sys_clk_i) begin
        if (any_reset) begin
            div_mode <= `MODE_RESET;
        end else if (wr_mode) begin
            div_mode <= reg_wdata_i[1:0];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i || wdt_reset_i) begin
            swallow_lsb_flag <= 1'b0;
        end else if (wr_mode) begin
            swallow_lsb_flag <= reg_wdata_i[`MODE_SWALLOW_LSB_BIT];
        end
    end

    // Flag is sampled only by the data write; later flag writes wait for the next one
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            divisor <= 17'h00000;
        end else if (periph_write_instr_i) begin
            divisor <= {divider_data_reg_i, swallow_lsb_flag};
        end
    end

    // ============================================================
    // Pin synchronisers
    logic [2:0] low_sync;
    logic [2:0] high_sync;
    logic [2:0] xtal_sync;

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            low_sync  <= 3'h0;
            high_sync <= 3'h0;
            xtal_sync <= 3'h0;
        end else begin
            low_sync  <= {low_sync[1:0], low_band_osc_in_i};
            high_sync <= {high_sync[1:0], high_band_osc_in_i};
            xtal_sync <= {xtal_sync[1:0], xtal_75k_i};
        end
    end

    // Edge detectors look only at the second and third stages
    wire logic low_edge  = low_sync[1] && !low_sync[2];
    wire logic high_edge = high_sync[1] && !high_sync[2];
    wire logic xtal_edge = xtal_sync[1] && !xtal_sync[2];

    // ============================================================
    // Input selection
    wire logic use_high  = div_mode_hi && !div_mode_lo;
    wire logic use_low   = div_mode_lo;
    wire logic sel_edge  = use_high ? high_edge : (use_low ? low_edge : 1'b0);

    // Disabled inputs are pulled down; selected input floats at mid level
    wire logic next_low_pd  = synth_off || !use_low;
    wire logic next_high_pd = synth_off || !use_high;

    // ============================================================
    // Divider and reference generator
    pll_core_if core ();

    assign core.enable       = !synth_off;
    assign core.swallow_mode = div_mode_hi;
    assign core.divisor      = divisor;
    assign core.in_edge      = sel_edge;
    assign core.ref_sel      = ref_sel;
    assign core.xtal_edge    = xtal_edge;

    prog_divider u_divider (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .core      (core.div)
    );

    ref_generator u_ref (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .core      (core.rgen)
    );

    wire logic div_pulse = core.div_pulse;
    wire logic ref_pulse = core.ref_pulse;

    // ============================================================
    // Phase comparator
    pll_synth_pkg::pfd_state_e state;
    pll_synth_pkg::pfd_state_e next_state;
    logic [3:0]                delay_cnt;

    // The common window after both edges sets the fixed request delay
    wire logic delay_done = (delay_cnt >= 4'(`REQ_DELAY_CYC - 1));

    always_comb begin
        next_state = state;
        case (state)
            pll_synth_pkg::PFD_IDLE: begin
                if (ref_pulse && div_pulse) begin
                    next_state = pll_synth_pkg::PFD_CLEAR;
                end else if (ref_pulse) begin
                    next_state = pll_synth_pkg::PFD_UP;
                end else if (div_pulse) begin
                    next_state = pll_synth_pkg::PFD_DOWN;
                end
            end
            pll_synth_pkg::PFD_UP: begin
                if (div_pulse) begin
                    next_state = pll_synth_pkg::PFD_CLEAR;
                end
            end
            pll_synth_pkg::PFD_DOWN: begin
                if (ref_pulse) begin
                    next_state = pll_synth_pkg::PFD_CLEAR;
                end
            end
            pll_synth_pkg::PFD_CLEAR: begin
                if (delay_done) begin
                    next_state = pll_synth_pkg::PFD_IDLE;
                end
            end
            default: next_state = pll_synth_pkg::PFD_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i || synth_off) begin
            state <= pll_synth_pkg::PFD_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i || state != pll_synth_pkg::PFD_CLEAR) begin
            delay_cnt <= 4'h0;
        end else begin
            delay_cnt <= delay_cnt + 4'h1;
        end
    end

    wire logic up_req   = (state == pll_synth_pkg::PFD_UP)
                       || (state == pll_synth_pkg::PFD_CLEAR);
    wire logic down_req = (state == pll_synth_pkg::PFD_DOWN)
                       || (state == pll_synth_pkg::PFD_CLEAR);

    // ============================================================
    // Charge pump
    // Equal phases leave the pins floating, so the loop filter holds its charge
    wire logic next_err_oe  = !synth_off && (up_req != down_req);
    wire logic next_err_lvl = down_req && !up_req;

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            error_out_a_o    <= 1'b0;
            error_out_a_oe_o <= 1'b0;
            error_out_b_o    <= 1'b0;
            error_out_b_oe_o <= 1'b0;
            up_request_n_o   <= 1'b1;
            down_request_n_o <= 1'b1;
            low_band_pd_o    <= 1'b1;
            high_band_pd_o   <= 1'b1;
        end else begin
            error_out_a_o    <= next_err_lvl;
            error_out_a_oe_o <= next_err_oe;
            error_out_b_o    <= next_err_lvl;
            error_out_b_oe_o <= next_err_oe;
            up_request_n_o   <= !up_req;
            down_request_n_o <= !down_req;
            low_band_pd_o    <= next_low_pd;
            high_band_pd_o   <= next_high_pd;
        end
    end

    // ============================================================
    // Lock loss detection
    // The shared clear window is not counted as a phase error
    logic err_seen;
    wire logic phase_err = up_req != down_req;

    always_ff @(posedge sys_clk_i) begin
        if (rst_i || synth_off || ref_pulse) begin
            err_seen <= 1'b0;
        end else if (phase_err) begin
            err_seen <= 1'b1;
        end
    end

    wire logic set_lock_loss = ref_pulse && (err_seen || phase_err);

    // Set wins over the clearing read so no error period is lost
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            lock_loss_bit <= 1'b0;
        end else if (set_lock_loss) begin
            lock_loss_bit <= 1'b1;
        end else if (rd_lock) begin
            lock_loss_bit <= 1'b0;
        end
    end

    // ============================================================
    // Read port
    // Writes to the lock loss address decode to nothing
    logic [3:0] next_rdata;

    always_comb begin
        case (reg_addr_i)
            `ADDR_MODE_SEL:  next_rdata = {swallow_lsb_flag, 1'b0, div_mode};
            `ADDR_REF_SEL:   next_rdata = {1'b0, ref_sel};
            `ADDR_LOCK_LOSS: next_rdata = {3'h0, lock_loss_bit};
            default:         next_rdata = 4'h0;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= 4'h0;
        end else if (periph_read_instr_i) begin
            reg_rdata_o <= next_rdata;
        end
    end

endmodule : pll_synth

// ---- pll_synth_consts.svh ----
// Constants for the synthesizer core: offsets, fields, resets, timing
// Notes on behaviour
// - Mode field: 00 inputs off, 01 direct low, 10 swallow high, 11 swallow low.
// - Direct mode takes low input, pulls high input down, uses programmable counter only.
// - Low-band swallow mode takes low input, pulls high down, uses both counters.
// - High-band swallow mode takes high input, pulls low down, uses both counters.
// - Inputs-off mode only pulls both inputs down; everything else keeps running.
// - Divider is 5-bit swallow plus 12-bit programmable counter, one 17-bit down counter.
// - Data word upper 12 bits program counter, low 4 bits swallow upper bits.
// - Direct uses upper 12 bits only; swallow mode uses all 17 bits.
// - Swallow LSB flag is captured only when the data word is written.
// - Mode bit 3 gives swallow LSB; mode bit 2 always reads zero.
// - Reference is made by dividing the 75 kHz oscillator clock.
// - Reference codes 1,3,5,6.25,12.5,25 kHz; 110/111 disable; bit 3 reads zero.
// - Disabled synthesizer pulls both inputs down and floats both error outputs.
// - Pin, watchdog and clock-stop resets force reference select to 0111.
// - Up request when divided frequency is lower, down request when higher.
// - Disabled synthesizer asserts neither up nor down request.
// - Error outputs low when reference leads, high when divided leads, else float.
// - Up and down requests carry a fixed 0.8 to 1.0 us delay.
// - Unlock flag set once per reference period if either request was low.
// - Unlock read returns flag in bit 0, zeros above, and clears it.
// - Unlock register is read-only; reads by peripheral read, writes ignored.
`ifndef PLL_SYNTH_CONSTS_SVH
`define PLL_SYNTH_CONSTS_SVH

// ============================================================
// Register addresses
`define ADDR_MODE_SEL      7'h10
`define ADDR_REF_SEL       7'h11
`define ADDR_LOCK_LOSS     7'h12

// ============================================================
// Fields and codes
`define MODE_SWALLOW_LSB_BIT 3
`define MODE_OFF           2'h0
`define MODE_DIRECT_LOW    2'h1
`define MODE_SWALLOW_HIGH  2'h2
`define MODE_SWALLOW_LOW   2'h3
`define MODE_RESET         2'h0
`define REF_SEL_RESET      3'h7
`define REF_RATIO_1K       7'h4B
`define REF_RATIO_3K       7'h19
`define REF_RATIO_5K       7'h0F
`define REF_RATIO_6K25     7'h0C
`define REF_RATIO_12K5     7'h06
`define REF_RATIO_25K      7'h03

// ============================================================
// Timing
`define CLK_PERIOD_NS      100
`define REQ_DELAY_MIN_NS   800
`define REQ_DELAY_CYC      ((`REQ_DELAY_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- pll_synth_pkg.sv ----
// Types shared by the synthesizer core
`include "pll_synth_consts.svh"
package pll_synth_pkg;

    typedef enum logic [1:0] {
        PFD_IDLE,
        PFD_UP,
        PFD_DOWN,
        PFD_CLEAR
    } pfd_state_e;

    // Reference ratio from select code; zero means disabled
    function automatic logic [6:0] ref_ratio(input logic [2:0] sel);
        case (sel)
            3'h0:    ref_ratio = `REF_RATIO_1K;
            3'h1:    ref_ratio = `REF_RATIO_3K;
            3'h2:    ref_ratio = `REF_RATIO_5K;
            3'h3:    ref_ratio = `REF_RATIO_6K25;
            3'h4:    ref_ratio = `REF_RATIO_12K5;
            3'h5:    ref_ratio = `REF_RATIO_25K;
            default: ref_ratio = 7'h00;
        endcase
    endfunction : ref_ratio

endpackage : pll_synth_pkg

// ---- pll_core_if.sv ----
// Carrier between the synthesizer top and its divider and reference blocks
`timescale 1ns/1ps
interface pll_core_if;
    logic        enable;
    logic        swallow_mode;
    logic [16:0] divisor;
    logic        in_edge;
    logic        div_pulse;
    logic [2:0]  ref_sel;
    logic        xtal_edge;
    logic        ref_pulse;

    modport top (output enable, output swallow_mode, output divisor, output in_edge,
                 output ref_sel, output xtal_edge, input div_pulse, input ref_pulse);
    modport div (input enable, input swallow_mode, input divisor, input in_edge,
                 output div_pulse);
    modport rgen (input enable, input ref_sel, input xtal_edge, output ref_pulse);
endinterface : pll_core_if

// ---- prog_divider.sv ----
// Programmable divider: swallow and programmable counters as one down counter
`timescale 1ns/1ps
`include "pll_synth_consts.svh"
module prog_divider (
    // Clock and reset
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    // Core carrier
    pll_core_if.div   core
);
    logic [16:0] count;
    logic [16:0] span;
    logic        terminal;

    // Direct mode ignores the swallow bits
    assign span     = core.swallow_mode ? core.divisor
                                        : {5'h00, core.divisor[16:5]};
    assign terminal = (count <= 17'h00001);

    always_ff @(posedge sys_clk_i) begin
        if (rst_i || !core.enable) begin
            count          <= span;
            core.div_pulse <= 1'b0;
        end else if (core.in_edge) begin
            count          <= terminal ? span : count - 17'h00001;
            core.div_pulse <= terminal;
        end else begin
            core.div_pulse <= 1'b0;
        end
    end
endmodule : prog_divider

// ---- ref_generator.sv ----
// Reference generator: divides oscillator edges down to the selected reference
`timescale 1ns/1ps
`include "pll_synth_consts.svh"
module ref_generator (
    // Clock and reset
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    // Core carrier
    pll_core_if.rgen  core
);
    logic [6:0] count;
    logic [6:0] ratio;

    assign ratio = pll_synth_pkg::ref_ratio(core.ref_sel);

    always_ff @(posedge sys_clk_i) begin
        if (rst_i || !core.enable) begin
            count          <= 7'h00;
            core.ref_pulse <= 1'b0;
        end else if (core.xtal_edge) begin
            count          <= (count >= ratio - 7'h01) ? 7'h00 : count + 7'h01;
            core.ref_pulse <= (count >= ratio - 7'h01);
        end else begin
            core.ref_pulse <= 1'b0;
        end
    end
endmodule : ref_generator

// ---- pll_synth_assertions.sv ----
// Port checker for the synthesizer core
`timescale 1ns/1ps
module pll_synth_assertions (
    // Clock and resets
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    input  wire logic       wdt_reset_i,
    input  wire logic       clock_stop_i,
    // Register port
    input  wire logic [6:0] reg_addr_i,
    input  wire logic       reg_wr_i,
    input  wire logic [3:0] reg_wdata_i,
    input  wire logic       periph_read_instr_i,
    input  wire logic [3:0] reg_rdata_o,
    // Pins
    input  wire logic       low_band_pd_o,
    input  wire logic       high_band_pd_o,
    input  wire logic       error_out_a_o,
    input  wire logic       error_out_a_oe_o,
    input  wire logic       error_out_b_o,
    input  wire logic       error_out_b_oe_o,
    input  wire logic       up_request_n_o,
    input  wire logic       down_request_n_o
);
    // ==========
    // Shadow of mode and reference select
    logic [1:0] mode_q;
    logic [2:0] ref_q;
    logic [3:0] quiet_cnt;
    logic       any_rst;
    logic       dis;
    logic       wr_cfg;
    assign any_rst = rst_i || wdt_reset_i || clock_stop_i;
    assign dis     = ref_q[2] && ref_q[1];
    assign wr_cfg  = reg_wr_i && (reg_addr_i == 7'h10 || reg_addr_i == 7'h11);
    always_ff @(posedge sys_clk_i) begin
        if (any_rst) begin
            mode_q <= 2'h0;
            ref_q  <= 3'h7;
        end else if (reg_wr_i && reg_addr_i == 7'h10) begin
            mode_q <= reg_wdata_i[1:0];
        end else if (reg_wr_i && reg_addr_i == 7'h11) begin
            ref_q <= reg_wdata_i[2:0];
        end
    end
    // Outputs trail the request delay line, so judge them only once settled
    always_ff @(posedge sys_clk_i) begin
        if (any_rst || wr_cfg) begin
            quiet_cnt <= 4'h0;
        end else if (quiet_cnt != 4'hF) begin
            quiet_cnt <= quiet_cnt + 4'h1;
        end
    end
    // ==========
    // Assertions
    default clocking dc @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);
    reset_vals_a: assert property ($fell(rst_i) |-> reg_rdata_o == 4'h0 && !error_out_a_oe_o
        && up_request_n_o && down_request_n_o && low_band_pd_o && high_band_pd_o)
        else $error("outputs wrong after reset");
    pair_match_a: assert property (error_out_a_o == error_out_b_o
        && error_out_a_oe_o == error_out_b_oe_o) else $error("error pins differ");
    drive_level_a: assert property (error_out_a_oe_o |-> error_out_a_o == up_request_n_o
        || error_out_a_o == $past(up_request_n_o)) else $error("error level wrong");
    idle_float_a: assert property (up_request_n_o && down_request_n_o &&
        $past(up_request_n_o && down_request_n_o) |-> !error_out_a_oe_o)
        else $error("error pin driven while idle");
    ref_read_a: assert property (periph_read_instr_i && reg_addr_i == 7'h11
        |=> reg_rdata_o == {1'b0, ref_q}) else $error("reference select read wrong");
    mode_read_a: assert property (periph_read_instr_i && reg_addr_i == 7'h10
        |=> reg_rdata_o[2:0] == {1'b0, mode_q}) else $error("mode read wrong");
    lock_read_a: assert property (periph_read_instr_i && reg_addr_i == 7'h12
        |=> reg_rdata_o[3:1] == 3'h0) else $error("lock loss upper bits set");
    unmapped_read_a: assert property (periph_read_instr_i && (reg_addr_i < 7'h10
        || reg_addr_i > 7'h12) |=> reg_rdata_o == 4'h0) else $error("unmapped read not zero");
    rdata_hold_a: assert property (!periph_read_instr_i && !wdt_reset_i && !clock_stop_i
        |=> $stable(reg_rdata_o)) else $error("read data moved");
    pd_map_a: assert property (quiet_cnt == 4'hF |-> low_band_pd_o == (dis || !mode_q[0])
        && high_band_pd_o == (dis || mode_q != 2'h2)) else $error("pull-down wrong");
    quiet_off_a: assert property (dis && quiet_cnt == 4'hF |-> up_request_n_o
        && down_request_n_o && !error_out_a_oe_o) else $error("disabled core active");
endmodule : pll_synth_assertions

// ---- vco_model.sv ----
// Behavioural external oscillator feeding one band input
`timescale 1ns/1ps
module vco_model (
    // Control
    input  wire logic [15:0] half_ns_i,
    input  wire logic        use_high_i,
    // Pull-downs from the core
    input  wire logic        low_band_pd_i,
    input  wire logic        high_band_pd_i,
    // Band inputs
    output      logic        low_band_o,
    output      logic        high_band_o
);
    // ==========
    // Oscillator; only the wired pin toggles, a pulled pin sits low
    logic osc = 1'b0;
    always #(half_ns_i) osc = ~osc;
    assign low_band_o  = !use_high_i && !low_band_pd_i && osc;
    assign high_band_o = use_high_i && !high_band_pd_i && osc;
endmodule : vco_model

// ---- tb_pll_synth.sv ----
// Self-checking bench for the synthesizer core
`timescale 1ns/1ps
`include "pll_synth_consts.svh"
module tb_pll_synth;
    // ==========
    // Signals
    logic        sys_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wdt_reset_i, clock_stop_i, reg_wr_i, periph_read_instr_i, periph_write_instr_i;
    logic        low_band_osc_in_i, high_band_osc_in_i, xtal_75k_i;
    logic [6:0]  reg_addr_i;
    logic [3:0]  reg_wdata_i, reg_rdata_o, m, r;
    logic [15:0] divider_data_reg_i;
    logic [15:0] half_ns = 16'h208D;
    logic        low_band_pd_o, high_band_pd_o, error_out_a_o, error_out_a_oe_o;
    logic        error_out_b_o, error_out_b_oe_o, up_request_n_o, down_request_n_o;
    logic        use_high = 1'b0;
    logic        pend = 1'b0;
    int          mismatches, checks_done, hi, lo;
    logic [3:0]  exp_q[$], msk_q[$];
    // Rows: N of 2 runs 20% above the reference, 3 runs 20% below, at this rate
    // A wide offset lets the pump sense settle whatever the starting phase
    logic [1:0]  r_mode [5] = '{2'h1, 2'h3, 2'h3, 2'h2, 2'h2};
    logic [15:0] r_data [5] = '{16'h0027, 16'h0001, 16'h0001, 16'h0001, 16'h0001};
    logic        r_flag [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
    logic        r_high [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    logic        r_down [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};

    pll_synth uut (.*);
    vco_model far (.half_ns_i(half_ns), .use_high_i(use_high), .low_band_pd_i(low_band_pd_o),
        .high_band_pd_i(high_band_pd_o), .low_band_o(low_band_osc_in_i),
        .high_band_o(high_band_osc_in_i));

    initial forever #50 sys_clk_i = ~sys_clk_i;
    initial begin
        xtal_75k_i = 1'b0;
        forever #6667 xtal_75k_i = ~xtal_75k_i;
    end
    // ==========
    // Tasks
    task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic acc(input logic w, input logic [6:0] a, input logic [3:0] d,
                       input logic [3:0] k);
        @(posedge sys_clk_i);
        #10;
        reg_addr_i = a;
        reg_wdata_i = d;
        if (w) begin
            reg_wr_i = 1'b1;
        end else begin
            periph_read_instr_i = 1'b1;
            exp_q.push_back(d);
            msk_q.push_back(k);
        end
        @(posedge sys_clk_i);
        #10;
        reg_wr_i = 1'b0;
        periph_read_instr_i = 1'b0;
    endtask : acc
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : wrap_up
    // ==========
    // Read monitor: answer lands one cycle after the strobe
    always @(posedge sys_clk_i) begin
        if (pend) begin
            m = msk_q.pop_front();
            check("read data", 16'(reg_rdata_o & m), 16'(exp_q.pop_front() & m));
        end
        pend = periph_read_instr_i;
    end
    initial begin
        repeat (40000) @(posedge sys_clk_i);
        mismatches++;
        wrap_up();
    end
    // ==========
    // Main sequence
    initial begin
        {wdt_reset_i, clock_stop_i, reg_wr_i, periph_read_instr_i, periph_write_instr_i} = 5'h00;
        reg_addr_i = 7'h00;
        reg_wdata_i = 4'h0;
        divider_data_reg_i = 16'h0000;
        void'($urandom(32'h7C677F20));
        repeat (5) @(posedge sys_clk_i);
        #10;
        rst_i = 1'b0;
        acc(0, `ADDR_REF_SEL, 4'h7, 4'hF);
        check("pull-downs", 16'({low_band_pd_o, high_band_pd_o}), 16'h0003);
        for (int c = 0; c < 8; c++) begin
            acc(1, `ADDR_REF_SEL, {1'($urandom), 3'(c)}, 4'h0);
            acc(0, `ADDR_REF_SEL, {1'b0, 3'(c)}, 4'hF);
        end
        acc(0, 7'($urandom_range(127, 19)), 4'h0, 4'hF);
        acc(1, `ADDR_REF_SEL, 4'h5, 4'h0);
        for (int k = 0; k < 4; k++) begin
            r = 4'($urandom);
            acc(1, `ADDR_MODE_SEL, {r[3:2], 2'(k)}, 4'h0);
            repeat (4) @(posedge sys_clk_i);
            #10;
            check("pull-downs", 16'({low_band_pd_o, high_band_pd_o}),
                16'({!k[0], k != 2}));
            acc(0, `ADDR_MODE_SEL, {r[3], 1'b0, 2'(k)}, 4'hF);
        end
        for (int k = 0; k < 5; k++) begin
            use_high = r_high[k];
            acc(1, `ADDR_MODE_SEL, {r_flag[k], 1'b0, r_mode[k]}, 4'h0);
            @(posedge sys_clk_i);
            #10;
            divider_data_reg_i = r_data[k];
            periph_write_instr_i = 1'b1;
            @(posedge sys_clk_i);
            #10;
            periph_write_instr_i = 1'b0;
            acc(1, `ADDR_MODE_SEL, {!r_flag[k], 1'b0, r_mode[k]}, 4'h0);
            repeat (2800) @(posedge sys_clk_i);
            hi = 0;
            lo = 0;
            repeat (3000) begin
                @(posedge sys_clk_i);
                #10;
                if (error_out_a_oe_o === 1'b1) begin
                    if (error_out_a_o) hi++;
                    else lo++;
                end
            end
            check("pump sense", 16'(hi > lo), 16'(r_down[k]));
            acc(0, `ADDR_LOCK_LOSS, 4'h1, 4'hF);
        end
        acc(1, `ADDR_REF_SEL, 4'h6, 4'h0);
        repeat (20) @(posedge sys_clk_i);
        #10;
        check("idle pins", 16'({up_request_n_o, down_request_n_o, error_out_a_oe_o,
            error_out_b_oe_o, low_band_pd_o, high_band_pd_o}), 16'h0033);
        acc(0, `ADDR_LOCK_LOSS, 4'h0, 4'h0);
        acc(1, `ADDR_LOCK_LOSS, 4'hF, 4'h0);
        repeat (500) @(posedge sys_clk_i);
        acc(0, `ADDR_LOCK_LOSS, 4'h0, 4'hF);
        for (int k = 0; k < 2; k++) begin
            acc(1, `ADDR_REF_SEL, 4'h2, 4'h0);
            acc(1, `ADDR_MODE_SEL, 4'hB, 4'h0);
            wdt_reset_i = (k == 0);
            clock_stop_i = (k == 1);
            @(posedge sys_clk_i);
            #10;
            wdt_reset_i = 1'b0;
            clock_stop_i = 1'b0;
            acc(0, `ADDR_REF_SEL, 4'h7, 4'hF);
            acc(0, `ADDR_MODE_SEL, {k[0], 3'h0}, {k[0], 3'h7});
        end
        repeat (2) @(posedge sys_clk_i);
        wrap_up();
    end
endmodule : tb_pll_synth

bind pll_synth pll_synth_assertions chk (.*);
